// *** rtl/i2c_led_test_target.sv ***
// Serial target port with LED connectivity test (external and field modes)
// What this block does
// (RULE1) Data changes only while clock low; device shifts out after falling edge.
// (RULE2) Data falling while clock high is a start; begins a session.
// (RULE3) Data rising while clock high is a stop; ends the session.
// (RULE4) Bus busy from start to stop, idle after stop.
// (RULE5) Repeated start handled exactly like a first start.
// (RULE6) Bytes are eight bits, MSB first, each followed by an acknowledge.
// (RULE7) Master clocks the acknowledge; transmitter releases data during it.
// (RULE8) Receiver pulls data low on the ninth pulse to acknowledge.
// (RULE9) Once addressed and receiving, device acknowledges every byte.
// (RULE10) First byte: seven-bit address then direction, 0 write, 1 read.
// (RULE11) Device answers only target address 4C hex.
// (RULE12) In a write, second byte is register address, third is data.
// (RULE13) Host sets register address by a write before reading.
// (RULE14) External test works without external reset or I/O supply.
// (RULE15) Stimulus low forces result low; high shows the current outcome.
// (RULE16) After power-on, stimulus high reports 1 when device is healthy.
// (RULE17) Then each further high phase reports one LED path connection.
// (RULE18) Final high phase of the pattern ends external test mode.
// (RULE19) Host writes 01h to register 0Ch to start the field test.
// (RULE20) Field test result readable at 0Ch in the next transaction.
// (RULE21) Host keeps serial clock at 50 kHz or below during the test.
// (RULE22) Result output settles within 10 us of each stimulus edge.
// (RULE23) Mismatched address is not acknowledged; rest of transaction ignored.
`timescale 1ns/1ps
module i2c_led_test_target #(
    parameter int paths = led_test_pkg::led_paths
) (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic rst, // Power-on reset, async, active high
    input wire logic ce, // Clock enable for mclk logic
    input wire logic scl, // Serial clock from the master
    input wire logic sda_in, // Serial data level on the wire
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe, // High while pulling data low
    input wire logic test_stimulus_in, // External test stimulus pin
    output logic test_result_out, // External test result pin
    input wire logic [paths-1:0] led_path_ok, // Analog comparators, one per LED path
    input wire logic chip_ok, // Internal health indication
    output logic bus_busy, // High between start and stop
    output logic field_test_active, // Field test in progress
    output logic [7:0] reg_wr_addr, // Register write address to register bank
    output logic [7:0] reg_wr_data, // Register write data
    output logic reg_wr_pulse, // One-cycle write strobe on mclk
    input wire logic [7:0] reg_rd_data // Other registers, read at reg pointer
);
    initial begin
        if (paths < 1 || paths > 8) begin
            $error("paths must be 1..8");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side: runs on scl (data samples on rising, drives on falling)

    // Start/stop detection: sda edges while scl high; async to scl domain
    logic start_tog_reg;
    logic stop_tog_reg;
    logic start_seen_reg;
    logic stop_seen_reg;

    always_ff @(negedge sda_in or posedge rst) begin
        if (rst) begin
            start_tog_reg <= 1'b0;
        end else if (scl) begin
            start_tog_reg <= ~start_tog_reg; // see (RULE2) see (RULE5)
        end
    end

    always_ff @(posedge sda_in or posedge rst) begin
        if (rst) begin
            stop_tog_reg <= 1'b0;
        end else if (scl) begin
            stop_tog_reg <= ~stop_tog_reg; // see (RULE3)
        end
    end

    typedef struct packed {
        led_test_pkg::link_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic got_ptr;
        logic rd;
        logic wr_ev;
        logic [15:0] wr_word;
        logic start_ack;
        logic stop_ack;
    } link_t;
    link_t lk_reg;
    link_t lk_next;
    logic sda_drive_reg;
    logic [7:0] rd_byte;
    logic start_now;
    logic [7:0] field_result;

    assign start_now = (start_tog_reg != lk_reg.start_ack);

    // Bit engine on rising scl; a pending start restarts the address phase
    always_comb begin
        lk_next = lk_reg;
        lk_next.wr_ev = 1'b0;
        if (start_now) begin
            lk_next.start_ack = start_tog_reg;
            // A start supersedes a stop still pending, which would end the new session
            lk_next.stop_ack = stop_tog_reg;
            lk_next.st = led_test_pkg::st_addr; // see (RULE5)
            lk_next.bitcnt = 4'h0;
            lk_next.got_ptr = 1'b0;
        end
        lk_next.shift = {lk_reg.shift[6:0], sda_in}; // see (RULE6)
        case (lk_next.st)
            led_test_pkg::st_addr, led_test_pkg::st_wr_byte: begin
                lk_next.bitcnt = lk_next.bitcnt + 4'h1;
                if (lk_next.bitcnt == 4'(led_test_pkg::byte_bits)) begin
                    lk_next.bitcnt = 4'h0;
                    if (lk_next.st == led_test_pkg::st_addr) begin
                        lk_next.rd = sda_in; // see (RULE10)
                        lk_next.st = (lk_next.shift[7:1] == led_test_pkg::target_addr) ?
                            led_test_pkg::st_addr_ack : led_test_pkg::st_ignore; // see (RULE11)
                    end else begin
                        lk_next.st = led_test_pkg::st_wr_ack;
                        if (!lk_reg.got_ptr) begin
                            lk_next.ptr = lk_next.shift; // see (RULE12)
                            lk_next.got_ptr = 1'b1;
                        end else begin
                            lk_next.wr_ev = 1'b1;
                            lk_next.wr_word = {lk_reg.ptr, lk_next.shift};
                            lk_next.ptr = lk_reg.ptr + 8'h01;
                        end
                    end
                end
            end
            led_test_pkg::st_addr_ack: begin
                lk_next.st = lk_reg.rd ? led_test_pkg::st_rd_byte : led_test_pkg::st_wr_byte;
            end
            led_test_pkg::st_wr_ack: lk_next.st = led_test_pkg::st_wr_byte;
            led_test_pkg::st_rd_byte: begin
                lk_next.bitcnt = lk_next.bitcnt + 4'h1;
                if (lk_next.bitcnt == 4'(led_test_pkg::byte_bits)) begin
                    lk_next.bitcnt = 4'h0;
                    lk_next.st = led_test_pkg::st_rd_ack;
                end
            end
            led_test_pkg::st_rd_ack: begin
                // Master nack ends our transmission until next start
                lk_next.st = sda_in ? led_test_pkg::st_ignore : led_test_pkg::st_rd_byte;
                lk_next.ptr = lk_reg.ptr + 8'h01;
            end
            default: lk_next.st = lk_next.st; // Idle or ignoring
        endcase
        if (stop_tog_reg != lk_reg.stop_ack && !start_now) begin
            lk_next.stop_ack = stop_tog_reg;
            lk_next.st = led_test_pkg::st_idle; // see (RULE3) see (RULE23)
        end
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    // Read data: test register gives the field result, others from the bank
    assign rd_byte = (lk_reg.ptr == led_test_pkg::test_reg_addr) ? field_result : reg_rd_data;

    // Drive on falling scl only, so data is steady while scl is high
    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            sda_drive_reg <= 1'b0;
        end else begin
            case (lk_reg.st)
                led_test_pkg::st_addr_ack, led_test_pkg::st_wr_ack:
                    sda_drive_reg <= 1'b1; // see (RULE1) see (RULE8) see (RULE9)
                led_test_pkg::st_rd_byte:
                    sda_drive_reg <= ~rd_byte[3'(7 - lk_reg.bitcnt)]; // see (RULE6)
                default: sda_drive_reg <= 1'b0; // see (RULE7) see (RULE23)
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_drive_reg;

    ////////////////////////////////////////////////////////////////////////
    // Crossings into mclk

    logic wr_pulse_m;
    logic [15:0] wr_word_m;
    logic start_lvl_m;
    logic stop_lvl_m;
    logic [2:0] stim_m;
    logic [paths-1:0] ok_m;
    logic chip_ok_m;

    toggle_sync #(.width(16)) u_wr_sync (
        .src_clk(scl),
        .dst_clk(mclk),
        .rst(rst),
        .ce(ce),
        .src_pulse(lk_reg.wr_ev),
        .src_data(lk_reg.wr_word),
        .dst_pulse(wr_pulse_m),
        .dst_data(wr_word_m)
    );

    sync_level #(.width(paths + 4)) u_lvl_sync (
        .clk(mclk),
        .rst(rst),
        .ce(ce),
        .d({start_tog_reg, stop_tog_reg, test_stimulus_in, chip_ok, led_path_ok}),
        .q({start_lvl_m, stop_lvl_m, stim_m[0], chip_ok_m, ok_m})
    );

    ////////////////////////////////////////////////////////////////////////
    // Core on mclk: bus state, test register, external and field tests

    typedef struct packed {
        logic start_d;
        logic stop_d;
        logic busy;
        logic stim_d;
        logic ext_active;
        logic [3:0] phase;
        logic result;
        logic [15:0] settle;
        logic [7:0] ctrl;
        logic field_run;
        logic [3:0] field_step;
        logic [7:0] field_fail;
        logic [7:0] wa;
        logic [7:0] wd;
        logic wp;
    } core_t;
    core_t c_reg;
    core_t c_next;

    assign stim_m[2:1] = '0;

    // Outcome of one high phase: 0 is chip health, later phases LED paths
    function automatic logic phase_ok(input logic [3:0] ph, input logic [paths-1:0] ok,
                                      input logic hlt);
        logic r;
        r = hlt;
        if (ph != 4'h0) begin
            r = (32'(ph) <= paths) ? ok[3'(ph - 4'h1)] : 1'b0;
        end
        return r;
    endfunction

    always_comb begin
        c_next = c_reg;
        c_next.wp = 1'b0;
        c_next.start_d = start_lvl_m;
        c_next.stop_d = stop_lvl_m;
        // Bus occupied from start to stop
        if (start_lvl_m != c_reg.start_d) begin
            c_next.busy = 1'b1; // see (RULE4)
        end else if (stop_lvl_m != c_reg.stop_d) begin
            c_next.busy = 1'b0; // see (RULE4)
        end
        // Register writes: forward all, keep the test register
        if (wr_pulse_m) begin
            c_next.wa = wr_word_m[15:8];
            c_next.wd = wr_word_m[7:0];
            c_next.wp = 1'b1;
            if (wr_word_m[15:8] == led_test_pkg::test_reg_addr) begin
                c_next.ctrl = led_test_pkg::test_reg_reset;
                if (wr_word_m[7:0] == led_test_pkg::test_start_val) begin
                    c_next.field_run = 1'b1; // see (RULE19)
                    c_next.field_step = 4'h0;
                    c_next.field_fail = '0;
                end
            end
        end
        // Field test walks each path; a busy bus gives the scan time
        if (c_reg.field_run && !wr_pulse_m) begin
            if (32'(c_reg.field_step) < paths) begin
                if (!ok_m[3'(c_reg.field_step)]) begin
                    c_next.field_fail[3'(c_reg.field_step)] = 1'b1;
                end
                c_next.field_step = c_reg.field_step + 4'h1;
            end else begin
                c_next.field_run = 1'b0;
                c_next.ctrl[led_test_pkg::bit_done] = 1'b1; // see (RULE20)
                c_next.ctrl[led_test_pkg::bit_pass] = (c_reg.field_fail == '0);
            end
        end
        // External test: no dependence on the external reset pin or io supply
        c_next.stim_d = stim_m[0]; // see (RULE14)
        if (c_reg.ext_active) begin
            if (stim_m[0] && !c_reg.stim_d) begin
                c_next.settle = 16'(led_test_pkg::settle_cycles - 1); // see (RULE22)
            end
            if (c_reg.settle != 16'h0) begin
                c_next.settle = c_reg.settle - 16'h1;
                if (c_reg.settle == 16'h1) begin
                    c_next.result = phase_ok(c_reg.phase, ok_m, chip_ok_m); // see (RULE16)
                end
            end
            if (!stim_m[0] && c_reg.stim_d) begin
                c_next.result = 1'b0; // see (RULE15)
                if (c_reg.phase == 4'h0 && !c_reg.result) begin
                    c_next.ext_active = 1'b0; // Unhealthy: no pattern follows
                end else if (32'(c_reg.phase) >= paths) begin
                    c_next.ext_active = 1'b0; // see (RULE18)
                end
                c_next.phase = c_reg.phase + 4'h1; // see (RULE17)
            end
        end
        if (!stim_m[0]) begin
            c_next.result = 1'b0; // see (RULE15)
        end
        if (!ce) begin
            c_next = c_reg;
        end
    end

    // Power-on enters external test mode, waiting for the stimulus
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            c_reg <= '0;
            c_reg.ext_active <= 1'b1;
            c_reg.ctrl <= led_test_pkg::test_reg_reset;
        end else begin
            c_reg <= c_next;
        end
    end

    // Field result word is quasi-static when read; reads are slow per the clock limit
    assign field_result = c_reg.ctrl; // see (RULE21)
    assign test_result_out = c_reg.result;
    assign bus_busy = c_reg.busy;
    assign field_test_active = c_reg.field_run;
    assign reg_wr_addr = c_reg.wa;
    assign reg_wr_data = c_reg.wd;
    assign reg_wr_pulse = c_reg.wp;
endmodule

// *** rtl/led_test_pkg.sv ***
// Package: constants and carriers for the serial target and LED connectivity test
package led_test_pkg;
    localparam logic [6:0] target_addr = 7'h4C;
    localparam logic [7:0] test_reg_addr = 8'h0C;
    localparam logic [7:0] test_start_val = 8'h01;
    localparam logic [7:0] test_reg_reset = 8'h00;
    localparam int byte_bits = 8;
    localparam int led_paths = 5;
    localparam int clk_mhz = 100;
    localparam int settle_us = 10;
    localparam int settle_cycles = settle_us * clk_mhz;
    localparam int field_steps = 8;
    localparam int bit_pass = 7;
    localparam int bit_done = 6;
    localparam int bit_start = 0;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wr_byte,
        st_wr_ack,
        st_rd_byte,
        st_rd_ack,
        st_ignore
    } link_state_t;

    // Register write event from link to core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;
endpackage

// *** rtl/sync_level.sv ***
// Two-stage level synchroniser
`timescale 1ns/1ps
module sync_level #(
    parameter int width = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rst, // Async reset, active high
    input wire logic ce, // Clock enable
    input wire logic [width-1:0] d, // Foreign level
    output logic [width-1:0] q // Synchronised level
);
    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
    } sync_state_t;
    sync_state_t state_reg;
    sync_state_t state_next;

    // First stage feeds only the second
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            state_next.s1 = d;
            state_next.s2 = state_reg.s1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.s2;
endmodule

// *** rtl/toggle_sync.sv ***
// Event crossing by toggle, carrying a data word sampled on arrival
`timescale 1ns/1ps
module toggle_sync #(
    parameter int width = 16
) (
    input wire logic src_clk, // Source clock
    input wire logic dst_clk, // Destination clock
    input wire logic rst, // Async reset, active high
    input wire logic ce, // Clock enable in destination domain
    input wire logic src_pulse, // Event in source domain
    input wire logic [width-1:0] src_data, // Word held stable after event
    output logic dst_pulse, // One-cycle event in destination
    output logic [width-1:0] dst_data // Word captured with the event
);
    logic tog_reg;
    logic [width-1:0] hold_reg;
    logic [2:0] sh_reg;
    logic [width-1:0] out_reg;
    logic pulse_reg;

    // Source toggles and freezes the word for the crossing
    always_ff @(posedge src_clk or posedge rst) begin
        if (rst) begin
            tog_reg <= 1'b0;
            hold_reg <= '0;
        end else if (src_pulse) begin
            tog_reg <= ~tog_reg;
            hold_reg <= src_data;
        end
    end

    // sh_reg[0] is read only by sh_reg[1]
    always_ff @(posedge dst_clk or posedge rst) begin
        if (rst) begin
            sh_reg <= '0;
            out_reg <= '0;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            sh_reg <= {sh_reg[1:0], tog_reg};
            // Strobe registered beside the word, else the strobe meets the old word
            pulse_reg <= (sh_reg[2] != sh_reg[1]);
            if (sh_reg[2] != sh_reg[1]) begin
                out_reg <= hold_reg;
            end
        end
    end

    assign dst_pulse = ce && pulse_reg;
    assign dst_data = out_reg;
endmodule

// *** tb/i2c_host_model.sv ***
// Serial bus master model: start, stop, byte write and read on an open-drain wire
`timescale 1ns/1ps
module i2c_host_model (
    output logic scl, // Clock, stands high outside frames
    output logic sda_low, // High while pulling data low
    input wire logic sda // Resolved data wire level
);
    localparam realtime q = 31.25;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One bit: data moves a quarter after the fall, sampled mid-high
    task automatic xfer(input logic b, output logic r);
        sda_low = !b;
        #q;
        scl = 1'b1;
        #q;
        r = sda;
        #q;
        scl = 1'b0;
        #q;
    endtask

    // Also serves as a repeated start from mid-frame
    task automatic start();
        sda_low = 1'b0;
        #q;
        scl = 1'b1;
        #q;
        sda_low = 1'b1;
        #q;
        scl = 1'b0;
        #q;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #q;
        scl = 1'b1;
        #q;
        sda_low = 1'b0;
        #(2 * q);
    endtask

    // MSB first, data released on the ninth pulse
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
        end
        xfer(1'b1, r);
        ack = !r;
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, r);
            d[i] = r;
        end
        xfer(nack, r);
    endtask
endmodule

// *** tb/led_test_checker.sv ***
// Concurrent checks on the serial target and test result pins
`timescale 1ns/1ps
module led_test_checker #(
    parameter int paths = led_test_pkg::led_paths
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Async reset
    input wire logic scl, // Serial clock
    input wire logic sda_in, // Data wire level
    input wire logic sda_out, // Data drive value
    input wire logic sda_oe, // Data drive enable
    input wire logic test_stimulus_in, // Stimulus pin
    input wire logic test_result_out, // Result pin
    input wire logic bus_busy, // Session flag
    input wire logic reg_wr_pulse // Write strobe
);
    localparam int settle_limit = led_test_pkg::settle_cycles + 8;
    logic [10:0] stim_cnt_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Cycles since stimulus rose, saturating
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stim_cnt_reg <= 11'h000;
        end else if (!test_stimulus_in) begin
            stim_cnt_reg <= 11'h000;
        end else if (stim_cnt_reg != 11'h7FF) begin
            stim_cnt_reg <= stim_cnt_reg + 11'h001;
        end
    end

    AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    AST_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    AST_START_BUSY: assert property (scl && $past(scl) && $fell(sda_in) |-> ##[1:8] bus_busy)
        else $error("start not seen as busy");
    AST_STOP_IDLE: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:8] !bus_busy)
        else $error("stop not seen as idle");
    AST_IDLE_QUIET: assert property (!bus_busy |-> !sda_oe)
        else $error("data driven while bus idle");
    AST_WR_ONE: assert property (reg_wr_pulse |=> !reg_wr_pulse)
        else $error("write strobe longer than one cycle");
    AST_WR_IN_SESSION: assert property (reg_wr_pulse |-> bus_busy)
        else $error("write strobe outside a session");
    AST_RESULT_LOW: assert property ((!test_stimulus_in) [*6] |-> !test_result_out)
        else $error("result high while stimulus low");
    AST_SETTLE: assert property ($rose(test_result_out) |-> stim_cnt_reg <= settle_limit)
        else $error("result settled too late");

    // Main scenarios reached
    COV_WRITE: cover property (reg_wr_pulse);
    COV_RESULT: cover property ($rose(test_result_out));
    COV_ACK: cover property ($rose(sda_oe));
endmodule

bind i2c_led_test_target led_test_checker #(.paths(paths)) chk (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .test_stimulus_in(test_stimulus_in),
    .test_result_out(test_result_out), .bus_busy(bus_busy), .reg_wr_pulse(reg_wr_pulse)
);

// *** tb/i2c_led_test_target_tb.sv ***
// Testbench for the serial target with LED connectivity test
`timescale 1ns/1ps
module i2c_led_test_target_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic stim = 1'b0;
    logic chip_ok = 1'b1;
    logic [4:0] path_ok = 5'b10110;
    logic scl, host_low, sda, sda_out, sda_oe, result, busy;
    logic [7:0] wr_addr, wr_data;
    logic wr_pulse, field_active;
    logic [15:0] wr_seen;
    int wr_count = 0;
    int failures = 0;
    int samples_checked = 0;
    logic ack;
    logic [7:0] rd;
    logic [15:0] rows [4] = '{16'h005A, 16'h02A5, 16'h03FF, 16'h1001};

    ////////////////////////////////////////////////////////////////////////
    always #5 mclk = ~mclk;
    // Pull-up wire: low when either side pulls
    assign sda = !(host_low || sda_oe);

    i2c_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));

    i2c_led_test_target uut (
        .mclk(mclk), .rst(rst), .ce(1'b1), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .test_stimulus_in(stim), .test_result_out(result),
        .led_path_ok(path_ok), .chip_ok(chip_ok), .bus_busy(busy),
        .field_test_active(field_active), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data),
        .reg_wr_pulse(wr_pulse), .reg_rd_data(8'h3C)
    );

    // Keep the latest register write seen, sampled away from its launching edge
    always @(negedge mclk) begin
        if (wr_pulse === 1'b1) begin
            wr_seen = {wr_addr, wr_data};
            wr_count++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checked=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic reset_dut();
        rst = 1'b1;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
    endtask

    // One stimulus high phase, result read once settled, then low phase
    task automatic stim_phase(input logic exp);
        @(negedge mclk) stim = 1'b1;
        repeat (1010) @(negedge mclk);
        check(16'(result), 16'(exp));
        stim = 1'b0;
        repeat (10) @(negedge mclk);
        check(16'(result), 16'h0000);
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        host.write_byte(d, ack);
        check(16'(ack), 16'(exp_ack));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #800000;
        failures++;
        stop_test();
    end

    initial begin
        reset_dut();
        // Power-on production test: health, then one phase per path
        stim_phase(1'b1);
        for (int p = 0; p < 5; p++) begin
            stim_phase(path_ok[p]);
        end
        stim_phase(1'b0);
        // Plain register writes from the table
        for (int i = 0; i < 4; i++) begin
            host.start();
            check(16'(busy), 16'h0001);
            send({led_test_pkg::target_addr, 1'b0}, 1'b1);
            send(rows[i][15:8], 1'b1);
            send(rows[i][7:0], 1'b1);
            host.stop();
            repeat (10) @(negedge mclk);
            check(16'(busy), 16'h0000);
            check(wr_seen, rows[i]);
        end
        check(16'(wr_count), 16'h0004);
        // Foreign address: no acknowledge, bytes ignored
        host.start();
        send({7'h4D, 1'b0}, 1'b0);
        send(8'h00, 1'b0);
        host.stop();
        repeat (10) @(negedge mclk);
        check(16'(wr_count), 16'h0004);
        // Pointer auto-increment, then repeated start into a read
        host.start();
        send({led_test_pkg::target_addr, 1'b0}, 1'b1);
        send(8'h05, 1'b1);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        host.start();
        send({led_test_pkg::target_addr, 1'b1}, 1'b1);
        host.read_byte(1'b1, rd);
        host.stop();
        check(wr_seen, 16'h0622);
        check(16'(wr_count), 16'h0006);
        check(16'(rd), 16'h003C);
        // Field self-test: start, then read the outcome
        path_ok = 5'b11111;
        host.start();
        send({led_test_pkg::target_addr, 1'b0}, 1'b1);
        send(led_test_pkg::test_reg_addr, 1'b1);
        send(led_test_pkg::test_start_val, 1'b1);
        host.stop();
        repeat (50) @(negedge mclk); // Scan done before the next transaction
        check(16'(field_active), 16'h0000);
        host.start();
        send({led_test_pkg::target_addr, 1'b0}, 1'b1);
        send(led_test_pkg::test_reg_addr, 1'b1);
        host.start();
        send({led_test_pkg::target_addr, 1'b1}, 1'b1);
        host.read_byte(1'b1, rd);
        host.stop();
        check(16'(rd[7:6]), 16'h0003);
        // Second power-on with an unhealthy chip
        chip_ok = 1'b0;
        reset_dut();
        stim_phase(1'b0);
        stop_test();
    end
endmodule
